// ---- include/thermo_pkg.sv ----
// Constants and types for the three-wire thermometer and thermostat.
// What this block does
// - Temperature is 9-bit two's complement, half-degree LSB
// - Over-limit high while temperature at or above upper
// - Under-limit high while temperature at or below lower
// - Hysteresis set at upper, cleared at lower
// - Config byte layout, done bit down to single bit
// - Done bit low during conversion, one at reset
// - Upper sticky flag sets, host clears, resets zero
// - Lower sticky flag sets, host clears, resets zero
// - Busy bit high during nonvolatile write, 10 ms
// - Host mode zero lets clock pin start conversions
// - Single bit: one conversion per start command
// - Single mode holds outputs until next completion
// - Serial port works in both host modes
// - Stand-alone pin pulse converts once, held low continuous
// - Stand-alone pin overrides single conversion bit
// - Enable frames transfer; low aborts and releases data
// - Read bits driven at fall, released while high
// - All words travel least significant bit first
// - Command AAh reads last temperature, nine bits
// - Commands 01h and 02h write trip points
// - Commands A1h and A2h read trip points
// - EEh starts conversions, 22h stops continuous
// - 0Ch writes config byte, ACh reads it
// - A0h reads count remaining, A9h reads slope
// - Zeros follow the last data bit
package thermo_pkg;

  // ******************************************************
  // Commands
  // ******************************************************
  localparam logic [7:0] CMD_READ_TEMP   = 8'hAA;
  localparam logic [7:0] CMD_WRITE_UPPER = 8'h01;
  localparam logic [7:0] CMD_WRITE_LOWER = 8'h02;
  localparam logic [7:0] CMD_READ_UPPER  = 8'hA1;
  localparam logic [7:0] CMD_READ_LOWER  = 8'hA2;
  localparam logic [7:0] CMD_READ_COUNT  = 8'hA0;
  localparam logic [7:0] CMD_READ_SLOPE  = 8'hA9;
  localparam logic [7:0] CMD_START_CONV  = 8'hEE;
  localparam logic [7:0] CMD_STOP_CONV   = 8'h22;
  localparam logic [7:0] CMD_WRITE_CFG   = 8'h0C;
  localparam logic [7:0] CMD_READ_CFG    = 8'hAC;

  // ******************************************************
  // Word sizes and config bit positions
  // ******************************************************
  localparam int         WORD_W      = 9;
  localparam int         CFG_W       = 8;
  localparam logic [3:0] CMD_LAST    = 4'h7;
  localparam logic [3:0] WORD_LAST   = 4'h8;
  localparam logic [3:0] CFG_LAST    = 4'h7;
  localparam int         BIT_DONE    = 7;
  localparam int         BIT_UPPER   = 6;
  localparam int         BIT_LOWER   = 5;
  localparam int         BIT_NVBUSY  = 4;
  localparam int         BIT_ONE     = 3;
  localparam int         BIT_ZERO    = 2;
  localparam int         BIT_HOST    = 1;
  localparam int         BIT_SINGLE  = 0;

  // ******************************************************
  // Reset and factory values
  // ******************************************************
  localparam logic [8:0] TEMP_RESET     = 9'h188;
  localparam logic [8:0] UPPER_FACTORY  = 9'h050;
  localparam logic [8:0] LOWER_FACTORY  = 9'h014;
  localparam logic       HOST_FACTORY   = 1'h0;
  localparam logic       SINGLE_FACTORY = 1'h0;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_KHZ          = 40000;
  localparam int CONV_TIME_MS     = 750;
  localparam int NV_WRITE_TIME_MS = 10;
  localparam int CONV_CYCLES_DEF  = CONV_TIME_MS * CLK_KHZ;
  localparam int NV_CYCLES_DEF    = NV_WRITE_TIME_MS * CLK_KHZ;
  localparam int CNT_W            = 25;

  // ******************************************************
  // Types
  // ******************************************************
  typedef struct packed {
    logic xfer_enable;
    logic clk;
    logic data;
  } three_wire_t;

  typedef struct packed {
    logic [8:0] temp;
    logic [8:0] count;
    logic [8:0] slope;
  } sensor_sample_t;

  typedef struct packed {
    logic over_limit;
    logic under_limit;
    logic hysteresis;
  } thermostat_t;

  typedef enum logic [3:0] {
    PH_CMD   = 4'h1,
    PH_WRITE = 4'h2,
    PH_READ  = 4'h4,
    PH_DONE  = 4'h8
  } phase_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'h1,
    CONV_BUSY = 2'h2
  } conv_state_t;

endpackage

// ---- hw/thermostat_three_wire_port.sv ----
// Three-wire serial port, conversion control and thermostat logic.
`timescale 1ns/100ps
module thermostat_three_wire_port #(
  parameter int CONV_CYCLES = thermo_pkg::CONV_CYCLES_DEF,
  parameter int NV_CYCLES   = thermo_pkg::NV_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       reset_in,
  // Three-wire pins, data pin split into in, out, enable
  input  wire thermo_pkg::three_wire_t    pins_in,
  output logic                            data_out,
  output logic                            data_oe_n_out,
  // Sensor front end, same clock domain
  input  wire thermo_pkg::sensor_sample_t sensor_in,
  output logic                            converting_out,
  // Thermostat outputs
  output thermo_pkg::thermostat_t         thermo_out
);
  import thermo_pkg::*;

  // ******************************************************
  // Behaviour notes
  // ******************************************************
  // Pins come from the host's world: each passes a two-flop
  // synchroniser, and a third flop keeps the last clock level
  // for edge finding. A link half-period must cover at least
  // three system cycles, or edges are lost.
  //
  // A transfer is framed by the enable pin. Its first eight
  // rising edges carry the command, least significant bit
  // first. Read bits are driven after a falling edge and
  // released after the next rising one, so a host sampling
  // on its own rising edge still sees the bit held.
  //
  // Written words commit only on their last bit. A frame cut
  // short by the enable pin leaves the stored value alone.
  //
  // Trip points and mode bits reload factory values at reset,
  // since no real nonvolatile cells sit behind them. The busy
  // bit still times a write, so software sees the usual wait.
  //
  // A conversion lasts CONV_CYCLES system cycles. The result,
  // the thermostat outputs and any sticky flag it sets change only
  // on its last cycle, so outputs never glitch mid-run.

  // ******************************************************
  // Elaboration checks
  // ******************************************************
  if (CONV_CYCLES < 1 || CONV_CYCLES > (1 << CNT_W)) begin : g_chk_conv
    $error("CONV_CYCLES out of range");
  end
  if (NV_CYCLES < 1 || NV_CYCLES > (1 << CNT_W)) begin : g_chk_nv
    $error("NV_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] NV_LAST   = CNT_W'(NV_CYCLES - 1);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    three_wire_t      sync1;
    three_wire_t      sync2;
    logic             clk_prev;
    phase_t           phase;
    logic [3:0]       bit_cnt;
    logic [7:0]       cmd;
    logic [8:0]       shreg;
    logic             dq;
    logic             dq_oe_n;
    logic [8:0]       temp;
    logic [8:0]       count;
    logic [8:0]       slope;
    logic [8:0]       upper;
    logic [8:0]       lower;
    logic             done;
    logic             up_flag;
    logic             lo_flag;
    logic             nv_busy;
    logic [CNT_W-1:0] nv_cnt;
    logic             host_mode;
    logic             single;
    conv_state_t      conv;
    logic [CNT_W-1:0] conv_cnt;
    logic             continuous;
    thermostat_t      thermo;
  } state_t;

  state_t s;
  state_t next_s;

  // ******************************************************
  // Functions
  // ******************************************************
  // Signed compare of two 9-bit temperatures, a >= b
  function automatic logic temp_ge(input logic [8:0] a,
                                   input logic [8:0] b);
    temp_ge = $signed(a) >= $signed(b);
  endfunction

  // Config byte as read back
  function automatic logic [7:0] cfg_byte(input state_t st);
    logic [7:0] c;
    c = 8'h00;
    c[BIT_DONE]   = st.done;
    c[BIT_UPPER]  = st.up_flag;
    c[BIT_LOWER]  = st.lo_flag;
    c[BIT_NVBUSY] = st.nv_busy;
    c[BIT_ONE]    = 1'b1;
    c[BIT_ZERO]   = 1'b0;
    c[BIT_HOST]   = st.host_mode;
    c[BIT_SINGLE] = st.single;
    cfg_byte = c;
  endfunction

  // ******************************************************
  // Next-state logic
  // ******************************************************
  logic       en;
  logic       rise;
  logic       fall;
  logic       din;
  logic [7:0] new_cmd;
  logic [8:0] new_word;
  logic       nv_start;
  logic       start_cmd;
  logic       stand_alone;
  logic       pin_low;
  logic       over;
  logic       under;

  always_comb begin
    next_s   = s;
    nv_start = 1'b0;
    start_cmd = 1'b0;
    // Pins pass two flops before use
    next_s.sync1    = pins_in;
    next_s.sync2    = s.sync1;
    next_s.clk_prev = s.sync2.clk;
    en       = s.sync2.xfer_enable;
    din      = s.sync2.data;
    rise     = s.sync2.clk & ~s.clk_prev;
    fall     = ~s.sync2.clk & s.clk_prev;
    new_cmd  = {din, s.cmd[7:1]};
    new_word = {din, s.shreg[8:1]};
    over     = 1'b0;
    under    = 1'b0;

    // Serial port, works whatever the host mode holds.
    // Enable low wins over every edge: the frame restarts
    // and the data pin is let go at once.
    if (!en) begin
      next_s.phase   = PH_CMD;
      next_s.bit_cnt = 4'h0;
      next_s.dq_oe_n = 1'b1;
      next_s.dq      = 1'b0;
    end else if (rise) begin
      next_s.dq_oe_n = 1'b1;
      unique case (s.phase)
        PH_CMD: begin
          next_s.cmd     = new_cmd;
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt == CMD_LAST) begin
            next_s.bit_cnt = 4'h0;
            next_s.shreg   = 9'h000;
            next_s.phase   = PH_DONE;
            unique case (new_cmd)
              CMD_READ_TEMP: begin
                next_s.shreg = s.temp;
                next_s.phase = PH_READ;
              end
              CMD_READ_UPPER: begin
                next_s.shreg = s.upper;
                next_s.phase = PH_READ;
              end
              CMD_READ_LOWER: begin
                next_s.shreg = s.lower;
                next_s.phase = PH_READ;
              end
              CMD_READ_COUNT: begin
                next_s.shreg = s.count;
                next_s.phase = PH_READ;
              end
              CMD_READ_SLOPE: begin
                next_s.shreg = s.slope;
                next_s.phase = PH_READ;
              end
              CMD_READ_CFG: begin
                next_s.shreg = {1'b0, cfg_byte(s)};
                next_s.phase = PH_READ;
              end
              CMD_WRITE_UPPER, CMD_WRITE_LOWER, CMD_WRITE_CFG: begin
                next_s.phase = PH_WRITE;
              end
              CMD_START_CONV: begin
                start_cmd = 1'b1;
                next_s.continuous = ~s.single;
              end
              CMD_STOP_CONV: begin
                next_s.continuous = 1'b0;
              end
              default: begin
                next_s.phase = PH_DONE;
              end
            endcase
          end
        end
        PH_WRITE: begin
          next_s.shreg   = new_word;
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.cmd == CMD_WRITE_CFG && s.bit_cnt == CFG_LAST) begin
            // Sticky flags only clear on a written zero
            next_s.up_flag   = s.up_flag & new_word[BIT_UPPER+1];
            next_s.lo_flag   = s.lo_flag & new_word[BIT_LOWER+1];
            next_s.host_mode = new_word[BIT_HOST+1];
            next_s.single    = new_word[BIT_SINGLE+1];
            nv_start         = 1'b1;
            next_s.phase     = PH_DONE;
          end else if (s.cmd != CMD_WRITE_CFG &&
                       s.bit_cnt == WORD_LAST) begin
            if (s.cmd == CMD_WRITE_UPPER) begin
              next_s.upper = new_word;
            end else begin
              next_s.lower = new_word;
            end
            nv_start     = 1'b1;
            next_s.phase = PH_DONE;
          end
        end
        PH_READ, PH_DONE: begin
          next_s.phase = s.phase;
        end
      endcase
    end else if (fall && s.phase == PH_READ) begin
      // Drive next bit, shift zeros in behind it
      next_s.dq      = s.shreg[0];
      next_s.dq_oe_n = 1'b0;
      next_s.shreg   = {1'b0, s.shreg[8:1]};
    end

    // Nonvolatile write timer.
    // A new write while busy restarts the count, so the
    // busy bit always covers the last write in full.
    if (nv_start) begin
      next_s.nv_busy = 1'b1;
      next_s.nv_cnt  = '0;
    end else if (s.nv_busy) begin
      next_s.nv_cnt = s.nv_cnt + CNT_W'(1);
      if (s.nv_cnt == NV_LAST) begin
        next_s.nv_busy = 1'b0;
      end
    end

    // Stand-alone conversion control from the clock pin.
    // Uses the mode bit as it will stand after this cycle,
    // so a config write takes effect without a stray start.
    // A pin held low keeps the engine running.
    stand_alone = ~next_s.host_mode & ~en;
    pin_low     = stand_alone & ~s.sync2.clk;
    if (stand_alone && fall) begin
      start_cmd = 1'b1;
    end

    // Conversion engine.
    // Idle waits for a start; busy counts to the end, then
    // latches the sample and either restarts or goes idle.
    // The done bit stays low through back-to-back runs.
    unique case (s.conv)
      CONV_IDLE: begin
        if (start_cmd) begin
          next_s.conv     = CONV_BUSY;
          next_s.conv_cnt = '0;
          next_s.done     = 1'b0;
        end
      end
      CONV_BUSY: begin
        next_s.conv_cnt = s.conv_cnt + CNT_W'(1);
        if (s.conv_cnt == CONV_LAST) begin
          next_s.temp  = sensor_in.temp;
          next_s.count = sensor_in.count;
          next_s.slope = sensor_in.slope;
          over  = temp_ge(sensor_in.temp, s.upper);
          under = temp_ge(s.lower, sensor_in.temp);
          next_s.thermo.over_limit  = over;
          next_s.thermo.under_limit = under;
          if (over) begin
            next_s.thermo.hysteresis = 1'b1;
          end else if (under) begin
            next_s.thermo.hysteresis = 1'b0;
          end
          // Set wins over a clear written in the same cycle
          next_s.up_flag = next_s.up_flag | over;
          next_s.lo_flag = next_s.lo_flag | under;
          next_s.conv_cnt = '0;
          if (!(next_s.continuous || pin_low || start_cmd)) begin
            next_s.conv = CONV_IDLE;
            next_s.done = 1'b1;
          end
        end
      end
    endcase
  end

  // ******************************************************
  // State register
  // ******************************************************
  // Reset loads only constants: factory trip points, done
  // set, data pin released, engine idle.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s            <= '0;
      s.phase      <= PH_CMD;
      s.dq_oe_n    <= 1'b1;
      s.temp       <= TEMP_RESET;
      s.upper      <= UPPER_FACTORY;
      s.lower      <= LOWER_FACTORY;
      s.done       <= 1'b1;
      s.host_mode  <= HOST_FACTORY;
      s.single     <= SINGLE_FACTORY;
      s.conv       <= CONV_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ******************************************************
  // Outputs, all from flops
  // ******************************************************
  // Nothing combinational reaches a pin, so the outputs
  // cannot glitch while the next state settles.
  assign data_out       = s.dq;
  assign data_oe_n_out  = s.dq_oe_n;
  assign converting_out = s.conv[1];
  assign thermo_out     = s.thermo;

endmodule

// ---- tb/thermo_checker.sv ----
// Port-level assertions for the thermometer and thermostat block.
`timescale 1ns/100ps
module thermo_checker
  import thermo_pkg::*;
#(
  parameter int CONV_CYCLES = 50
) (
  // Clock and reset
  input wire logic                       sys_clk_in,
  input wire logic                       reset_in,
  // Three-wire port
  input wire thermo_pkg::three_wire_t    pins_in,
  input wire logic                       data_out,
  input wire logic                       data_oe_n_out,
  // Sensor and thermostat
  input wire thermo_pkg::sensor_sample_t sensor_in,
  input wire logic                       converting_out,
  input wire thermo_pkg::thermostat_t    thermo_out
);
  // ****
  // Helpers
  // ****
  int run_len;

  // Counts the cycles of the current conversion run
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      run_len <= 0;
    end else begin
      run_len <= converting_out ? run_len + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  // Port rules
  a_release_on_disable: assert property (
    !pins_in.xfer_enable [*6] |-> data_oe_n_out)
    else $error("data pin driven outside a transfer");
  a_release_clock_high: assert property (
    pins_in.clk [*6] |-> data_oe_n_out)
    else $error("data pin driven while clock high");
  a_drive_after_fall: assert property (
    $fell(data_oe_n_out) |-> !$past(pins_in.clk) && pins_in.xfer_enable)
    else $error("data pin driven without a falling clock");
  a_bit_change_low: assert property (
    !data_oe_n_out && $changed(data_out) |-> !$past(pins_in.clk))
    else $error("read bit changed while clock high");
  a_thermo_hold: assert property (
    !converting_out |=> $stable(thermo_out))
    else $error("thermostat outputs moved without a conversion");
  a_over_sets_hyst: assert property (
    thermo_out.over_limit |-> thermo_out.hysteresis)
    else $error("over-limit high with hysteresis low");
  a_under_clears_hyst: assert property (
    thermo_out.under_limit |-> !thermo_out.hysteresis
      && !thermo_out.over_limit)
    else $error("under-limit high with hysteresis or over high");
  a_conv_length: assert property (
    $fell(converting_out) |-> run_len >= CONV_CYCLES - 1)
    else $error("conversion ended too early");
endmodule

bind thermostat_three_wire_port thermo_checker #(
  .CONV_CYCLES(CONV_CYCLES)
) chk (
  .sys_clk_in(sys_clk_in),
  .reset_in(reset_in),
  .pins_in(pins_in),
  .data_out(data_out),
  .data_oe_n_out(data_oe_n_out),
  .sensor_in(sensor_in),
  .converting_out(converting_out),
  .thermo_out(thermo_out)
);

// ---- tb/host_model.sv ----
// Behavioural host driving the three-wire port.
`timescale 1ns/100ps
module host_model
  import thermo_pkg::*;
(
  // Clock and device data pin
  input  wire logic               sys_clk_in,
  input  wire logic               data_in,
  input  wire logic               data_oe_n_in,
  // Resolved pins towards the device
  output thermo_pkg::three_wire_t pins_out
);
  // ****
  // Pin drivers
  // ****
  logic en   = 1'h0;
  logic ck   = 1'h1;
  logic hd   = 1'h0;
  logic hen  = 1'h0;
  logic junk = 1'h0;
  logic line;

  // A released line shows a changing pattern, never the last value
  always @(posedge sys_clk_in) junk <= ~junk;
  assign line     = !data_oe_n_in ? data_in : hen ? hd : junk;
  assign pins_out = {en, ck, line};

  // Half a link clock period is four system cycles
  task automatic half();
    repeat (4) @(posedge sys_clk_in);
  endtask

  // One write bit: fall, present data, rise with data valid
  task automatic put(input logic b);
    ck  <= 1'h0;
    hd  <= b;
    hen <= 1'h1;
    half();
    ck <= 1'h1;
    half();
  endtask

  // Whole frame: command, nw write bits, nr read bits
  task automatic xfer(input logic [7:0] cmd, input int nw,
                      input logic [8:0] wd, input int nr,
                      output logic [10:0] rd);
    rd = '0;
    en <= 1'h1;
    half();
    for (int i = 0; i < 8; i++) put(cmd[i]);
    for (int i = 0; i < nw; i++) put(wd[i]);
    hen <= 1'h0;
    for (int i = 0; i < nr; i++) begin
      ck <= 1'h0;
      half();
      ck <= 1'h1;
      repeat (2) @(posedge sys_clk_in);
      rd[i] = line;
      repeat (2) @(posedge sys_clk_in);
    end
    half();
    en <= 1'h0;
    repeat (32) @(posedge sys_clk_in);
  endtask

  // Stand-alone convert pulse on the clock pin
  task automatic pulse(input int n);
    ck <= 1'h0;
    repeat (n) @(posedge sys_clk_in);
    ck <= 1'h1;
    half();
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the thermometer and thermostat block.
`timescale 1ns/100ps
module testbench;
  import thermo_pkg::*;
  // ****
  // Bench state
  // ****
  localparam int  CONV = 50;
  logic           sys_clk_in = 1'h0;
  logic           reset_in = 1'h1;
  three_wire_t    pins;
  sensor_sample_t sensor = '0;
  logic           data_out;
  logic           data_oe_n_out;
  logic           converting_out;
  thermostat_t    thermo_out;
  thermostat_t    exp_tst = '0;
  logic           fu = 1'h0;
  logic           fl = 1'h0;
  logic [10:0]    junk;
  int             errors = 0;
  int             n_tests = 0;
  int             ti;
  int             ui;
  int             li;

  thermostat_three_wire_port #(.CONV_CYCLES(CONV), .NV_CYCLES(20)) dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .pins_in(pins),
    .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .sensor_in(sensor), .converting_out(converting_out),
    .thermo_out(thermo_out));
  host_model host (.sys_clk_in(sys_clk_in), .data_in(data_out),
    .data_oe_n_in(data_oe_n_out), .pins_out(pins));

  // 40 MHz system clock
  always #12.5 sys_clk_in = ~sys_clk_in;

  task automatic chk_word(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_tst(input thermostat_t got, input thermostat_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Thermostat state after a conversion of temperature t
  function automatic thermostat_t next_tst(input int t, input thermostat_t p);
    thermostat_t e;
    e.over_limit  = t >= ui;
    e.under_limit = t <= li;
    e.hysteresis  = e.over_limit ? 1'h1 : e.under_limit ? 1'h0 : p.hysteresis;
    return e;
  endfunction
  task automatic settle(input int t);
    exp_tst = next_tst(t, exp_tst);
    fu |= exp_tst.over_limit;
    fl |= exp_tst.under_limit;
    chk_tst(thermo_out, exp_tst);
  endtask
  task automatic rd(input logic [7:0] c, input int n, input logic [10:0] e);
    logic [10:0] got;
    host.xfer(c, 0, 9'h000, n, got);
    chk_word(got, e);
  endtask
  task automatic wr(input logic [7:0] c, input int n, input logic [8:0] d);
    host.xfer(c, n, d, 0, junk);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 400 && converting_out !== 1'h0; k++)
      @(posedge sys_clk_in);
    chk_word({10'h000, converting_out}, 11'h000);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h74DF));
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'h0;
    repeat (4) @(posedge sys_clk_in);
    rd(CMD_READ_CFG, 8, 11'h088);
    rd(CMD_READ_TEMP, 9, {2'h0, TEMP_RESET});
    rd(CMD_READ_UPPER, 9, {2'h0, UPPER_FACTORY});
    rd(CMD_READ_LOWER, 9, {2'h0, LOWER_FACTORY});
    wr(CMD_WRITE_CFG, 8, 9'h003);
    rd(CMD_READ_CFG, 8, 11'h08B);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      ui = int'($urandom % 200) - 60;
      li = ui - 1 - int'($urandom % 40);
      ti = i == 0 ? ui : i == 1 ? li : ui + int'($urandom % 90) - 60;
      sensor <= {ti[8:0], 9'($urandom), 9'($urandom)};
      wr(CMD_WRITE_UPPER, 9, ui[8:0]);
      wr(CMD_WRITE_LOWER, 9, li[8:0]);
      rd(CMD_READ_UPPER, 9, {2'h0, ui[8:0]});
      rd(CMD_READ_LOWER, 11, {2'h0, li[8:0]});
      chk_tst(thermo_out, exp_tst);
      wr(CMD_START_CONV, 0, 9'h000);
      wait_idle();
      settle(ti);
      rd(CMD_READ_TEMP, 11, {2'h0, ti[8:0]});
      rd(CMD_READ_COUNT, 9, {2'h0, sensor.count});
      rd(CMD_READ_SLOPE, 9, {2'h0, sensor.slope});
      rd(CMD_READ_CFG, 8, {3'h0, 1'h1, fu, fl, 5'h0B});
    end
    done("random");
    wr(CMD_WRITE_CFG, 8, 9'h003);
    fu = 1'h0;
    fl = 1'h0;
    rd(CMD_READ_CFG, 8, 11'h08B);
    host.xfer(CMD_WRITE_UPPER, 4, 9'h1FF, 0, junk);
    rd(CMD_READ_UPPER, 9, {2'h0, ui[8:0]});
    done("abort");
    wr(CMD_WRITE_CFG, 8, 9'h002);
    ti = ui + 1;
    sensor.temp <= ti[8:0];
    wr(CMD_START_CONV, 0, 9'h000);
    repeat (3 * CONV) @(posedge sys_clk_in);
    chk_word({10'h000, converting_out}, 11'h001);
    wr(CMD_STOP_CONV, 0, 9'h000);
    wait_idle();
    settle(ti);
    rd(CMD_READ_CFG, 8, {3'h0, 1'h1, fu, fl, 5'h0A});
    done("continuous");
    wr(CMD_WRITE_CFG, 8, 9'h001);
    ti = li - 3;
    sensor.temp <= ti[8:0];
    host.pulse(12);
    repeat (8) @(posedge sys_clk_in);
    chk_word({10'h000, converting_out}, 11'h001);
    wait_idle();
    settle(ti);
    rd(CMD_READ_TEMP, 9, {2'h0, ti[8:0]});
    done("standalone");
    summarize();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    errors++;
    summarize();
  end
endmodule
